// *** pgo_pkg.sv ***
// Constants and state type for the power-good output configuration block
// What this block does
// - Config bit 7 picks output B mode: unusual conditions, or requested outputs invalid.
// - Config bit 3 picks output A mode: unusual conditions, or requested outputs invalid.
// - Config bit 6 makes output B follow live status or its latched fault flags.
// - Config bit 2 makes output A follow live status or its latched fault flags.
// - Config bit 4 sets output B polarity: 0 high when valid, 1 low.
// - Config bit 0 sets output A polarity: 0 high when valid, 1 low.
// - Config bit 1 picks output A push-pull or open-drain; config resets to 02h.
// - Source-select bit 7 delays output A going valid by 11 ms.
// - Source-select bits 6..0 mask a source at 0, let it act at 1.
// - Boost window code in bits 7-6 selects +/-2, 4, 6 or 8 percent.
// - Step-down one window code in bits 3-2 selects +/-30 to 90 mV.
// - Step-down zero window code in bits 1-0 uses the same encoding.
// - Config, source-select and window defaults, boost threshold included, load from programmable memory; the interrupt mask resets to 0.
// - A source that drove output A inactive latches a flag; W1C once valid again.
package pgo_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [7:0] PGO_IDX_WIN     = 8'h16;
	localparam logic [7:0] PGO_IDX_CFG     = 8'h17;
	localparam logic [7:0] PGO_IDX_SEL_A   = 8'h18;
	localparam logic [7:0] PGO_IDX_FLT_A   = 8'h19;
	localparam logic [7:0] PGO_IDX_SEL_B   = 8'h1A;
	localparam logic [7:0] PGO_IDX_FLT_B   = 8'h1B;
	localparam logic [7:0] PGO_IDX_INT_ST  = 8'h20;
	localparam logic [7:0] PGO_IDX_INT_MSK = 8'h21;

	// Configuration register fields
	localparam int PGO_CFG_B_MODE = 7;
	localparam int PGO_CFG_B_GATE = 6;
	localparam int PGO_CFG_B_POL  = 4;
	localparam int PGO_CFG_A_MODE = 3;
	localparam int PGO_CFG_A_GATE = 2;
	localparam int PGO_CFG_A_OD   = 1;
	localparam int PGO_CFG_A_POL  = 0;

	// Source-select fields
	localparam int PGO_SEL_DELAY = 7;
	localparam int PGO_NSRC      = 7;

	// Window register fields
	localparam int PGO_WIN_BOOST_LSB = 6;
	localparam int PGO_WIN_BTHR_LSB  = 4;
	localparam int PGO_WIN_SD1_LSB   = 2;
	localparam int PGO_WIN_SD0_LSB   = 0;

	// Reset values before the programmable defaults are copied in
	localparam logic [7:0] PGO_CFG_RST = 8'h02;
	localparam logic [7:0] PGO_SEL_RST = 8'h00;
	localparam logic [7:0] PGO_WIN_RST = 8'h00;
	localparam logic [7:0] PGO_CFG_MASK = 8'hDF;

	// Rise delay timing
	localparam int PGO_CLK_HZ       = 100_000_000;
	localparam int PGO_RISE_DLY_MS  = 11;
	localparam int PGO_RISE_DLY_CYC = PGO_RISE_DLY_MS * (PGO_CLK_HZ / 1000);
	localparam int PGO_DLY_W        = 21;

	typedef struct packed {
		logic [7:0]          cfg;
		logic [7:0]          sel_a;
		logic [7:0]          sel_b;
		logic [7:0]          win;
		logic [6:0]          flt_a;
		logic [6:0]          flt_b;
		logic [1:0]          int_st;
		logic [1:0]          int_msk;
		logic                ack;
		logic [31:0]         rdat;
		logic [6:0]          s1;
		logic [6:0]          s2;
		logic [6:0]          s3;
		logic [6:0]          vld;
		logic [PGO_DLY_W-1:0] dly;
		logic                a_lvl;
		logic                a_oe;
		logic                b_lvl;
		logic                irq;
		logic                otp_pend;
	} pgo_state_t;

endpackage

// *** pgo_output_cfg.sv ***
// Power-good output shaping, fault latches and Wishbone register bank
`timescale 1ns/1ps
module pgo_output_cfg
	import pgo_pkg::*;
#(
	parameter int RISE_DLY_CYC = PGO_RISE_DLY_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Programmable-memory defaults
	input  wire logic [7:0]  otp_cfg_i,
	input  wire logic [7:0]  otp_sel_a_i,
	input  wire logic [7:0]  otp_sel_b_i,
	input  wire logic [7:0]  otp_win_i,
	// Monitored sources, bit 6 thermal warning down to bit 0 step-down zero
	input  wire logic [6:0]  src_valid_i,
	input  wire logic [6:0]  src_active_i,
	// Window codes to the comparators
	output logic      [1:0]  stepup_window_code_o,
	output logic      [1:0]  stepup_threshold_code_o,
	output logic      [1:0]  stepdown_one_window_code_o,
	output logic      [1:0]  stepdown_zero_window_code_o,
	// Power-good pins
	output logic             powergood_out_a_o,
	output logic             powergood_out_a_oe_o,
	output logic             powergood_out_b_o,
	// Interrupt
	output logic             irq_o
);

	pgo_state_t r;
	pgo_state_t n;

	// Sources that make an output invalid; mode selects what counts
	function automatic logic [6:0] pgo_bad(
		input logic [7:0] sel,
		input logic [6:0] vld,
		input logic [6:0] act,
		input logic       mode
	);
		logic [6:0] b;
		if (mode) begin
			// Requested outputs: not running or out of window both count
			b = ~(vld & act);
		end else begin
			// Unusual conditions: only a running source leaving its window
			b = act & ~vld;
		end
		return sel[6:0] & b;
	endfunction

	// Pin level from validity and polarity
	function automatic logic pgo_level(
		input logic valid,
		input logic pol
	);
		return valid ^ pol;
	endfunction

	logic [7:0]  idx;
	logic        req;
	logic        wr;
	logic [7:0]  wb;
	logic [6:0]  bad_a;
	logic [6:0]  bad_b;
	logic [6:0]  clr_a;
	logic [6:0]  clr_b;
	logic [1:0]  ev;
	logic [1:0]  clr_int;
	logic        live_a;
	logic        live_b;
	logic        ready_a;
	logic        dly_done;
	logic [31:0] rd;

	always_comb begin
		n = r;
		idx = adr_i[9:2];
		req = cyc_i & stb_i & ~r.ack;
		wr = req & we_i & sel_i[0];
		wb = dat_i[7:0];

		// Three-stage synchroniser; a change counts once stages two and three agree
		n.s1 = src_valid_i;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.vld = (r.s3 & ~(r.s2 ^ r.s3)) | (r.vld & (r.s2 ^ r.s3));

		// Unmasked running sources that are out of window, or in requested-outputs mode any unmasked source out of window or not running
		bad_a = pgo_bad(r.sel_a, r.vld, src_active_i,
			r.cfg[PGO_CFG_A_MODE]);
		bad_b = pgo_bad(r.sel_b, r.vld, src_active_i,
			r.cfg[PGO_CFG_B_MODE]);

		// Write-one clears only for sources valid again; a new fault wins
		clr_a = '0;
		clr_b = '0;
		clr_int = '0;
		if (wr && idx == PGO_IDX_FLT_A) begin
			clr_a = wb[6:0] & ~bad_a;
		end
		if (wr && idx == PGO_IDX_FLT_B) begin
			clr_b = wb[6:0] & ~bad_b;
		end
		if (wr && idx == PGO_IDX_INT_ST) begin
			clr_int = wb[1:0];
		end
		n.flt_a = (r.flt_a & ~clr_a) | bad_a;
		n.flt_b = (r.flt_b & ~clr_b) | bad_b;

		// Interrupt events: a fault flag newly latched
		ev = {|(bad_b & ~r.flt_b), |(bad_a & ~r.flt_a)};
		n.int_st = (r.int_st & ~clr_int) | ev;
		n.irq = |(r.int_st & r.int_msk);

		// Live status or latched flags
		if (r.cfg[PGO_CFG_A_GATE]) begin
			live_a = ~|r.flt_a;
		end else begin
			live_a = ~|bad_a;
		end
		if (r.cfg[PGO_CFG_B_GATE]) begin
			live_b = ~|r.flt_b;
		end else begin
			live_b = ~|bad_b;
		end

		// Going invalid is immediate; going valid may wait for the delay
		dly_done = (r.dly == RISE_DLY_CYC[PGO_DLY_W-1:0]);
		if (!live_a) begin
			n.dly = '0;
		end else if (!dly_done) begin
			n.dly = r.dly + 1'b1;
		end
		ready_a = live_a & (~r.sel_a[PGO_SEL_DELAY] | dly_done);

		// Pin drive: open drain only pulls low, push-pull always drives
		n.a_lvl = pgo_level(ready_a, r.cfg[PGO_CFG_A_POL]);
		n.a_oe = r.cfg[PGO_CFG_A_OD] ?
			~n.a_lvl : 1'b1;
		n.b_lvl = pgo_level(live_b, r.cfg[PGO_CFG_B_POL]);

		// Read mux; unmapped addresses read zero
		rd = '0;
		unique case (idx)
			PGO_IDX_WIN:     rd[7:0] = r.win;
			PGO_IDX_CFG:     rd[7:0] = r.cfg;
			PGO_IDX_SEL_A:   rd[7:0] = r.sel_a;
			PGO_IDX_FLT_A:   rd[6:0] = r.flt_a;
			PGO_IDX_SEL_B:   rd[7:0] = r.sel_b;
			PGO_IDX_FLT_B:   rd[6:0] = r.flt_b;
			PGO_IDX_INT_ST:  rd[1:0] = r.int_st;
			PGO_IDX_INT_MSK: rd[1:0] = r.int_msk;
			default:         rd = '0;
		endcase

		// Registered ack, one request per two cycles at most
		n.ack = req;
		if (req) begin
			n.rdat = rd;
		end
		if (wr) begin
			unique case (idx)
				PGO_IDX_WIN:     n.win = wb;
				PGO_IDX_CFG:     n.cfg = wb & PGO_CFG_MASK;
				PGO_IDX_SEL_A:   n.sel_a = wb;
				PGO_IDX_SEL_B:   n.sel_b = wb;
				PGO_IDX_INT_MSK: n.int_msk = wb[1:0];
				default:         n.win = r.win;
			endcase
		end

		// Defaults arrive from programmable memory the cycle after reset
		if (r.otp_pend) begin
			n.cfg = otp_cfg_i & PGO_CFG_MASK;
			n.sel_a = otp_sel_a_i;
			n.sel_b = otp_sel_b_i;
			n.win = otp_win_i;
			n.otp_pend = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.cfg <= PGO_CFG_RST;
			r.sel_a <= PGO_SEL_RST;
			r.sel_b <= PGO_SEL_RST;
			r.win <= PGO_WIN_RST;
			r.otp_pend <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Outputs straight from the state register
	assign dat_o = r.rdat;
	assign ack_o = r.ack;
	assign stepup_window_code_o = r.win[PGO_WIN_BOOST_LSB +: 2];
	assign stepup_threshold_code_o = r.win[PGO_WIN_BTHR_LSB +: 2];
	assign stepdown_one_window_code_o = r.win[PGO_WIN_SD1_LSB +: 2];
	assign stepdown_zero_window_code_o = r.win[PGO_WIN_SD0_LSB +: 2];
	assign powergood_out_a_o = r.a_lvl;
	assign powergood_out_a_oe_o = r.a_oe;
	assign powergood_out_b_o = r.b_lvl;
	assign irq_o = r.irq;

endmodule

// *** pgo_output_cfg_props.sv ***
// Bus, pin and window-code checks for the power-good output block
`timescale 1ns/1ps
module pgo_output_cfg_props (
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic        ack_o,
	input wire logic [31:0] dat_o,
	// Outputs
	input wire logic        powergood_out_a_o,
	input wire logic        powergood_out_a_oe_o,
	input wire logic [1:0]  stepup_window_code_o,
	input wire logic [1:0]  stepdown_one_window_code_o,
	input wire logic [1:0]  stepdown_zero_window_code_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [2:0] hist_reg;
	logic       req;
	logic       fresh;
	// Defaults and pins settle over the first edges after reset
	always_ff @(posedge clk_i) hist_reg <= {hist_reg[1:0], rst_i};
	assign fresh = |hist_reg;
	assign req = cyc_i && stb_i && !ack_o;
	ack_once_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	ack_resp_a: assert property (req |=> ack_o) else $error("no ack");
	rdat_hold_a: assert property (!req |=> $stable(dat_o))
		else $error("read data moved");
	top_zero_a: assert property (ack_o && !$past(we_i) |-> !(|dat_o[31:8]))
		else $error("upper read bits set");
	od_drive_a: assert property (
		!fresh && !powergood_out_a_oe_o |-> powergood_out_a_o)
		else $error("released pin A not high");
	win_up_a: assert property (
		$changed(stepup_window_code_o) |-> ack_o || $past(ack_o) || fresh)
		else $error("step-up code moved alone");
	win_sd1_a: assert property (
		$changed(stepdown_one_window_code_o) |-> ack_o || $past(ack_o) || fresh)
		else $error("step-down one code moved alone");
	win_sd0_a: assert property (
		$changed(stepdown_zero_window_code_o) |-> ack_o || $past(ack_o) || fresh)
		else $error("step-down zero code moved alone");
	cover property (ack_o && $past(we_i));
	cover property (!fresh && !powergood_out_a_oe_o);
	cover property ($rose(powergood_out_a_o));
endmodule
bind pgo_output_cfg pgo_output_cfg_props pgo_output_cfg_props_inst (.clk_i,
	.rst_i, .cyc_i, .stb_i, .we_i, .ack_o, .dat_o, .powergood_out_a_o,
	.powergood_out_a_oe_o, .stepup_window_code_o,
	.stepdown_one_window_code_o, .stepdown_zero_window_code_o);

// *** pgo_sys_ctrl.sv ***
// System controller model reading the power-good pins
`timescale 1ns/1ps
module pgo_sys_ctrl (
	// Pins from the block
	input  wire logic level_a_i,
	input  wire logic oe_a_i,
	input  wire logic level_b_i,
	// Levels as the controller reads them
	output logic      seen_a_o,
	output logic      seen_b_o
);
	// Released pin A floats up to the pull-up resistor
	assign seen_a_o = oe_a_i ? level_a_i : 1'b1;
	assign seen_b_o = level_b_i;
endmodule

// *** test_pgo_output_cfg.sv ***
// Self-checking bench for the power-good output block
`timescale 1ns/1ps
module test_pgo_output_cfg;
	import pgo_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [9:0] adr_i = 0;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic ack_o, a_lvl, a_oe, b_lvl, irq_o, seen_a, seen_b;
	logic [6:0] src_valid_i = 7'h7F, src_active_i = 7'h7F;
	logic [1:0] up_w, up_t, sd1_w, sd0_w;
	int bad_count = 0, checks = 0, cyc_n = 0;
	pgo_output_cfg #(.RISE_DLY_CYC(20)) pgo_output_cfg_inst (.clk_i, .rst_i,
		.cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.otp_cfg_i(8'h02), .otp_sel_a_i(8'h00), .otp_sel_b_i(8'h00),
		.otp_win_i(8'hE4), .src_valid_i, .src_active_i,
		.stepup_window_code_o(up_w), .stepup_threshold_code_o(up_t),
		.stepdown_one_window_code_o(sd1_w),
		.stepdown_zero_window_code_o(sd0_w), .powergood_out_a_o(a_lvl),
		.powergood_out_a_oe_o(a_oe), .powergood_out_b_o(b_lvl), .irq_o);
	pgo_sys_ctrl pgo_sys_ctrl_inst (.level_a_i(a_lvl), .oe_a_i(a_oe),
		.level_b_i(b_lvl), .seen_a_o(seen_a), .seen_b_o(seen_b));
	always #5 clk_i = ~clk_i;
	// Cut a hang short well past the expected run length
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 6000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(logic w, logic [7:0] idx, logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
		if (ack_o !== 1'b1) begin
			bad_count++;
			$display("FAIL ack expected 1 seen %b", ack_o);
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic rdchk(string nm, logic [7:0] idx, logic [7:0] e);
		wb(1'b0, idx, 8'h00);
		cmp(nm, {24'h0, e}, rd);
	endtask
	// Source changes pass a three-stage synchroniser first
	task automatic pins(logic ea, logic eb);
		repeat (8) @(posedge clk_i);
		cmp("pin a", {31'h0, ea}, {31'h0, seen_a});
		cmp("pin b", {31'h0, eb}, {31'h0, seen_b});
	endtask
	task automatic t_reset();
		rdchk("cfg", PGO_IDX_CFG, 8'h02);
		rdchk("win", PGO_IDX_WIN, 8'hE4);
		cmp("codes", {up_w, up_t, sd1_w, sd0_w}, 8'hE4);
		rdchk("unmapped", 8'h30, 8'h00);
		wb(1'b1, PGO_IDX_WIN, 8'h1B);
		repeat (2) @(posedge clk_i);
		cmp("codes", {up_w, up_t, sd1_w, sd0_w}, 8'h1B);
	endtask
	task automatic cfg_pins(logic [7:0] c, logic [6:0] v, logic ea, eb);
		wb(1'b1, PGO_IDX_CFG, c);
		src_valid_i <= v;
		pins(ea, eb);
	endtask
	task automatic t_live();
		wb(1'b1, PGO_IDX_SEL_A, 8'h07);
		wb(1'b1, PGO_IDX_SEL_B, 8'h01);
		cfg_pins(8'h00, 7'h7F, 1, 1);
		cfg_pins(8'h00, 7'h5F, 1, 1);
		cfg_pins(8'h00, 7'h7D, 0, 1);
		cfg_pins(8'h11, 7'h7D, 1, 0);
		cfg_pins(8'h11, 7'h7F, 0, 0);
		cfg_pins(8'h02, 7'h7F, 1, 1);
		cmp("oe", 0, a_oe);
		cfg_pins(8'h02, 7'h7E, 0, 0);
		src_active_i <= 7'h7E;
		cfg_pins(8'h88, 7'h7F, 0, 0);
		cfg_pins(8'h00, 7'h7F, 1, 1);
		src_active_i <= 7'h7F;
	endtask
	task automatic t_fault();
		wb(1'b1, PGO_IDX_FLT_A, 8'h7F);
		wb(1'b1, PGO_IDX_FLT_B, 8'h7F);
		wb(1'b1, PGO_IDX_INT_ST, 8'h03);
		wb(1'b1, PGO_IDX_INT_MSK, 8'h01);
		cfg_pins(8'h04, 7'h7B, 0, 1);
		rdchk("flags", PGO_IDX_FLT_A, 8'h04);
		cmp("irq", 1, irq_o);
		wb(1'b1, PGO_IDX_FLT_A, 8'h04);
		rdchk("flags", PGO_IDX_FLT_A, 8'h04);
		cfg_pins(8'h04, 7'h7F, 0, 1);
		wb(1'b1, PGO_IDX_FLT_A, 8'h04);
		rdchk("flags", PGO_IDX_FLT_A, 8'h00);
		pins(1, 1);
		rdchk("status", PGO_IDX_INT_ST, 8'h01);
		wb(1'b1, PGO_IDX_INT_MSK, 8'h00);
		pins(1, 1);
		cmp("irq", 0, irq_o);
		wb(1'b1, PGO_IDX_INT_MSK, 8'h01);
		pins(1, 1);
		cmp("irq", 1, irq_o);
		wb(1'b1, PGO_IDX_INT_ST, 8'h01);
		pins(1, 1);
		cmp("irq", 0, irq_o);
		// Output B gated by its latched flag stays invalid after recovery
		cfg_pins(8'h40, 7'h7E, 0, 0);
		cfg_pins(8'h40, 7'h7F, 1, 0);
	endtask
	task automatic t_delay();
		wb(1'b1, PGO_IDX_SEL_A, 8'h81);
		cfg_pins(8'h00, 7'h7E, 0, 0);
		src_valid_i <= 7'h7F;
		pins(0, 1);
		repeat (20) @(posedge clk_i);
		cmp("pin a late", 1, seen_a);
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		t_reset();
		t_live();
		t_fault();
		t_delay();
		end_sim();
	end
endmodule
